// ==== design/lmr_pkg.sv ====
// Package with register map, field layouts and shared types of the result bank.
// Operation
// - L apparent power: bit15 zero, milli units
// - N current rms: unsigned 16-bit, milliamperes
// - N active power: two's complement, milli kW
// - N reactive power: two's complement, milli kvar
// - N power factor: sign-magnitude, thousandths
// - N apparent power: bit15 zero, milli units
// - All result registers ignore host writes
package lmr_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;

    // Register addresses in the host address space.
    localparam logic [ADDR_W-1:0] ADDR_L_APPARENT = 8'h4F;
    localparam logic [ADDR_W-1:0] ADDR_N_CURRENT = 8'h68;
    localparam logic [ADDR_W-1:0] ADDR_N_ACTIVE = 8'h6A;
    localparam logic [ADDR_W-1:0] ADDR_N_REACTIVE = 8'h6B;
    localparam logic [ADDR_W-1:0] ADDR_N_PFACTOR = 8'h6D;
    localparam logic [ADDR_W-1:0] ADDR_N_ANGLE = 8'h6E;
    localparam logic [ADDR_W-1:0] ADDR_N_APPARENT = 8'h6F;

    // Field layout and limits.
    localparam int SIGN_BIT = 15;
    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
    localparam logic [DATA_W-1:0] POS_MAX = 16'h7FFF;
    localparam logic [DATA_W-2:0] PF_MAG_MAX = 15'h03E8;
    localparam logic [DATA_W-2:0] ANGLE_MAG_MAX = 15'h0708;

    // Indices of the results inside the bank.
    localparam int NUM_RES = 7;
    localparam logic [2:0] IDX_L_APPARENT = 3'h0;
    localparam logic [2:0] IDX_N_CURRENT = 3'h1;
    localparam logic [2:0] IDX_N_ACTIVE = 3'h2;
    localparam logic [2:0] IDX_N_REACTIVE = 3'h3;
    localparam logic [2:0] IDX_N_PFACTOR = 3'h4;
    localparam logic [2:0] IDX_N_ANGLE = 3'h5;
    localparam logic [2:0] IDX_N_APPARENT = 3'h6;

    // One result delivered by the metering computation.
    typedef struct packed {
        logic valid;
        logic [2:0] index;
        logic [DATA_W-1:0] value;
    } lmr_update_s;

    // One host register access.
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } lmr_access_s;

    // Answer to a host read.
    typedef struct packed {
        logic valid;
        logic hit;
        logic [DATA_W-1:0] data;
    } lmr_answer_s;

endpackage : lmr_pkg

// ==== design/lmr_format.sv ====
// Formatter that forces each computed result into its documented encoding.
module lmr_format
    import lmr_pkg::*;
(
    // Raw result.
    input wire logic [2:0] index,
    input wire logic [DATA_W-1:0] rawValue,
    // Encoded result.
    output logic [DATA_W-1:0] fmtValue
);

    // Clamp a sign-magnitude word to a magnitude limit; minus zero reads as zero.
    function automatic logic [DATA_W-1:0] clampSm(input logic [DATA_W-1:0] v,
                                                  input logic [DATA_W-2:0] lim);
        logic [DATA_W-2:0] mag;
        mag = (v[DATA_W-2:0] > lim) ? lim : v[DATA_W-2:0];
        clampSm = (mag == '0) ? ZERO_WORD : {v[SIGN_BIT], mag};
    endfunction : clampSm

    // Apply the per-register encoding.
    always_comb
    begin
        fmtValue = rawValue;
        unique case (index)
            IDX_L_APPARENT: fmtValue = rawValue & POS_MAX;
            IDX_N_APPARENT: fmtValue = rawValue & POS_MAX;
            IDX_N_PFACTOR: fmtValue = clampSm(rawValue, PF_MAG_MAX);
            IDX_N_ANGLE: fmtValue = clampSm(rawValue, ANGLE_MAG_MAX);
            default: fmtValue = rawValue;
        endcase
    end

endmodule : lmr_format

// ==== design/lmr_result_bank.sv ====
// Read-only bank of L and N line measurement results with host read port.
module lmr_result_bank
    import lmr_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Results from the metering computation.
    input wire lmr_update_s update,
    // Host access, already decoded from the serial port.
    input wire lmr_access_s access,
    // Answer to the host.
    output lmr_answer_s answer
);

    // Whole state of the bank.
    typedef struct packed {
        logic [NUM_RES-1:0][DATA_W-1:0] res;
        lmr_answer_s ans;
    } lmr_state_s;

    lmr_state_s state_q;
    lmr_state_s state_d;
    logic [DATA_W-1:0] fmtValue;

    // Map an address to its bank index; hit low for unmapped addresses.
    function automatic logic [3:0] decodeAddr(input logic [ADDR_W-1:0] a);
        unique case (a)
            ADDR_L_APPARENT: decodeAddr = {1'b1, IDX_L_APPARENT};
            ADDR_N_CURRENT: decodeAddr = {1'b1, IDX_N_CURRENT};
            ADDR_N_ACTIVE: decodeAddr = {1'b1, IDX_N_ACTIVE};
            ADDR_N_REACTIVE: decodeAddr = {1'b1, IDX_N_REACTIVE};
            ADDR_N_PFACTOR: decodeAddr = {1'b1, IDX_N_PFACTOR};
            ADDR_N_ANGLE: decodeAddr = {1'b1, IDX_N_ANGLE};
            ADDR_N_APPARENT: decodeAddr = {1'b1, IDX_N_APPARENT};
            default: decodeAddr = 4'h0;
        endcase
    endfunction : decodeAddr

    // Encoding of the incoming result.
    lmr_format u_format (
        .index(update.index),
        .rawValue(update.value),
        .fmtValue(fmtValue)
    );

    // Next-state logic: results stored, reads answered, writes ignored.
    always_comb
    begin
        logic [3:0] dec;
        dec = decodeAddr(access.addr);
        state_d = state_q;
        if (update.valid && (update.index < 3'(NUM_RES)))
        begin
            state_d.res[update.index] = fmtValue;
        end
        // Reads return stored value, no clearing.
        state_d.ans.valid = access.read;
        state_d.ans.hit = access.read && dec[3];
        state_d.ans.data = (access.read && dec[3]) ? state_q.res[dec[2:0]] : ZERO_WORD;
    end

    // State register.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign answer = state_q.ans;

    // Assertions.
    logic [3:0] decNow;
    assign decNow = decodeAddr(access.addr);

    a_write_no_effect: assert property (@(posedge core_clk) disable iff (rst)
        (access.write && !update.valid) |=> (state_q.res == $past(state_q.res)))
        else $error("Host write changed a result.");
    a_read_no_clear: assert property (@(posedge core_clk) disable iff (rst)
        (access.read && !update.valid) |=> (state_q.res == $past(state_q.res)))
        else $error("Read disturbed the results.");
    a_read_data: assert property (@(posedge core_clk) disable iff (rst)
        (access.read && decNow[3]) |=> (answer.valid && answer.hit
            && answer.data == $past(state_q.res[decNow[2:0]])))
        else $error("Read returned wrong data.");
    a_unmapped_zero: assert property (@(posedge core_clk) disable iff (rst)
        (access.read && !decNow[3]) |=> (!answer.hit && answer.data == ZERO_WORD))
        else $error("Unmapped read not zero.");
    a_lapp_sign: assert property (@(posedge core_clk) disable iff (rst)
        !state_q.res[IDX_L_APPARENT][SIGN_BIT])
        else $error("L apparent power negative.");
    a_napp_sign: assert property (@(posedge core_clk) disable iff (rst)
        !state_q.res[IDX_N_APPARENT][SIGN_BIT])
        else $error("N apparent power negative.");
    a_pf_range: assert property (@(posedge core_clk) disable iff (rst)
        state_q.res[IDX_N_PFACTOR][DATA_W-2:0] <= PF_MAG_MAX)
        else $error("Power factor over unity.");
    a_angle_range: assert property (@(posedge core_clk) disable iff (rst)
        state_q.res[IDX_N_ANGLE][DATA_W-2:0] <= ANGLE_MAG_MAX)
        else $error("Phase angle over limit.");
    a_current_store: assert property (@(posedge core_clk) disable iff (rst)
        (update.valid && update.index == IDX_N_CURRENT)
            |=> state_q.res[IDX_N_CURRENT] == $past(update.value))
        else $error("Current rms not stored as is.");
    a_active_store: assert property (@(posedge core_clk) disable iff (rst)
        (update.valid && update.index == IDX_N_ACTIVE)
            |=> state_q.res[IDX_N_ACTIVE] == $past(update.value))
        else $error("Active power not stored as is.");
    a_reactive_store: assert property (@(posedge core_clk) disable iff (rst)
        (update.valid && update.index == IDX_N_REACTIVE)
            |=> state_q.res[IDX_N_REACTIVE] == $past(update.value))
        else $error("Reactive power not stored as is.");

    c_read_hit: cover property (@(posedge core_clk) disable iff (rst)
        access.read && decNow[3]);
    c_write_try: cover property (@(posedge core_clk) disable iff (rst)
        access.write && decNow[3]);
    c_neg_pf: cover property (@(posedge core_clk) disable iff (rst)
        state_q.res[IDX_N_PFACTOR][SIGN_BIT]);

endmodule : lmr_result_bank

// ==== tb/lmr_host_model.sv ====
// Host controller model that reads and writes result registers.
module lmr_host_model
    import lmr_pkg::*;
(
    // Clock.
    input wire logic core_clk,
    // Access out, answer in.
    output lmr_access_s access,
    input wire lmr_answer_s answer
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle access at time zero.
    initial access = '0;

    // Raw words only.
    // Any current or power rescaling is left to host software.
    task automatic rd(input logic [ADDR_W-1:0] a, output lmr_answer_s r);
        @(negedge core_clk);
        access.read = 1'b1;
        access.addr = a;
        @(negedge core_clk);
        access.read = 1'b0;
        access.addr = ~a;
        r = answer;
    endtask : rd

    // One write pulse, which the device is expected to ignore.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge core_clk);
        access.write = 1'b1;
        access.addr = a;
        access.wdata = d;
        @(negedge core_clk);
        access.write = 1'b0;
        access.wdata = ~d;
    endtask : wr
endmodule : lmr_host_model

// ==== tb/tb_top.sv ====
// Testbench for the line measurement result bank.
module tb_top
    import lmr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    lmr_update_s update = '0;
    lmr_access_s access;
    lmr_answer_s answer;
    int errCount = 0;
    int checked = 0;

    // Clock of 20 ns.
    always #10 core_clk = ~core_clk;

    lmr_result_bank i_dut (.core_clk(core_clk), .rst(rst), .update(update),
        .access(access), .answer(answer));
    lmr_host_model i_host (.core_clk(core_clk), .access(access), .answer(answer));

    // Counts one comparison and reports a mismatch.
    task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checked++;
        if (got !== exp)
        begin
            errCount++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    // Reads one address and checks flags and data.
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
        input logic h);
        lmr_answer_s r;
        i_host.rd(a, r);
        cmp({14'h0, r.valid, r.hit}, {14'h0, 1'b1, h});
        cmp(r.data, d);
    endtask : rchk

    // Delivers one result from the metering side.
    task automatic upd(input logic [2:0] i, input logic [DATA_W-1:0] v);
        @(negedge core_clk);
        update = '{valid: 1'b1, index: i, value: v};
        @(negedge core_clk);
        update = '0;
    endtask : upd

    // Ends the run with the verdict.
    task automatic report_and_stop();
        $display("checked %0d errors %0d", checked, errCount);
        if (errCount == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    // Unsigned and always-positive encodings.
    task automatic test_unsigned();
        upd(IDX_L_APPARENT, 16'hFFFF);
        rchk(ADDR_L_APPARENT, 16'h7FFF, 1'b1);
        upd(IDX_N_CURRENT, 16'hFFFF);
        rchk(ADDR_N_CURRENT, 16'hFFFF, 1'b1);
        upd(IDX_N_APPARENT, 16'h8123);
        rchk(ADDR_N_APPARENT, 16'h0123, 1'b1);
    endtask : test_unsigned

    // Two's complement powers: active at the negative end, reactive at the positive end of the range.
    task automatic test_signed();
        upd(IDX_N_ACTIVE, 16'h8000);
        rchk(ADDR_N_ACTIVE, 16'h8000, 1'b1);
        upd(IDX_N_REACTIVE, 16'h7FFF);
        rchk(ADDR_N_REACTIVE, 16'h7FFF, 1'b1);
    endtask : test_signed

    // Sign-magnitude factor and angle, with clamping.
    task automatic test_sign_mag();
        upd(IDX_N_PFACTOR, 16'h83E8);
        rchk(ADDR_N_PFACTOR, 16'h83E8, 1'b1);
        upd(IDX_N_PFACTOR, 16'h07FF);
        rchk(ADDR_N_PFACTOR, 16'h03E8, 1'b1);
        upd(IDX_N_ANGLE, 16'h8FFF);
        rchk(ADDR_N_ANGLE, 16'h8708, 1'b1);
    endtask : test_sign_mag

    // Writes ignored, repeated reads stable, unmapped read misses.
    task automatic test_read_only();
        i_host.wr(ADDR_N_CURRENT, 16'h1234);
        rchk(ADDR_N_CURRENT, 16'hFFFF, 1'b1);
        rchk(ADDR_N_CURRENT, 16'hFFFF, 1'b1);
        rchk(8'h50, 16'h0000, 1'b0);
    endtask : test_read_only

    // Watchdog against a hang.
    initial
    begin
        #100000;
        errCount++;
        report_and_stop();
    end

    // Main sequence.
    initial
    begin
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        rchk(ADDR_N_ACTIVE, 16'h0000, 1'b1);
        test_unsigned();
        test_signed();
        test_sign_mag();
        test_read_only();
        report_and_stop();
    end
endmodule : tb_top
